// file: fecp_cfg.svh
/*
  Constants for the flash and EEPROM command and protection logic:
  register offsets, field positions, command codes, reset values.
  Assumes it is included by bare name after fecp_pkg.sv is compiled.
*/
`ifndef FECP_CFG_SVH
`define FECP_CFG_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses on the plain register port)
// ----------------------------------------------------------------
`define FECP_OFF_STAT   4'h0
`define FECP_OFF_CMD    4'h1
`define FECP_OFF_IDX    4'h2
`define FECP_OFF_SLOTHI 4'h3
`define FECP_OFF_SLOTLO 4'h4
`define FECP_OFF_PPROT  4'h5
`define FECP_OFF_EPROT  4'h6
`define FECP_OFF_MODE   4'h7

// ----------------------------------------------------------------
// Status register bit positions
// ----------------------------------------------------------------
`define FECP_ST_CCF     7
`define FECP_ST_ACC     5
`define FECP_ST_PV      4
`define FECP_ST_MG1     1
`define FECP_ST_MG0     0

// ----------------------------------------------------------------
// Protection register fields
// ----------------------------------------------------------------
`define FECP_PP_OPEN    7
`define FECP_PP_HDIS    5
`define FECP_PP_LDIS    2
`define FECP_EP_OPEN    7
`define FECP_PP_RST     8'hFF
`define FECP_EP_RST     8'h80

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define FECP_CMD_EVSEC  8'h03
`define FECP_CMD_RDONCE 8'h04
`define FECP_CMD_ERALL  8'h08
`define FECP_CMD_ERBLK  8'h09
`define FECP_CMD_UNSEC  8'h0B
`define FECP_CMD_UMARG  8'h0D
`define FECP_CMD_FMARG  8'h0E
`define FECP_CMD_EVEE   8'h10
`define FECP_CMD_PGMEE  8'h11
`define FECP_CMD_ERSEC  8'h12

// ----------------------------------------------------------------
// Indices, addresses and timing
// ----------------------------------------------------------------
`define FECP_IDX_LAST2  3'h2
`define FECP_IDX_MAX    3'h5
`define FECP_PF_BANK    2'h3
`define FECP_LOW_BASE   18'h38000
`define FECP_HIGH_TOP   18'h3FFFF
`define FECP_CFG_ADDR   18'h3FF0D
`define FECP_BLOCK_SZ   19'h10000
`define FECP_ONCE_MAX   16'h0007
`define FECP_INIT_CYC   4'h3
`define FECP_EXEC_CYC   4'h4

`endif

// file: fecp_pkg.sv
/*
  Types for the flash and EEPROM command and protection logic.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package fecp_pkg;

  // ----------------------------------------------------------------
  // Controller state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FECP_INIT = 2'b00,
    FECP_IDLE = 2'b01,
    FECP_EXEC = 2'b10
  } fecp_state_t;

  // Class of operation running on one array, for concurrency checks.
  typedef enum logic [2:0] {
    FECP_OP_NONE  = 3'b000,
    FECP_OP_READ  = 3'b001,
    FECP_OP_MREAD = 3'b010,
    FECP_OP_PROG  = 3'b011,
    FECP_OP_SERA  = 3'b100,
    FECP_OP_MASS  = 3'b101
  } fecp_op_t;

  // Whole module state, one register bank.
  typedef struct packed {
    fecp_state_t      st;
    logic [3:0]       cnt;
    logic             ccf;
    logic             acc;
    logic             pv;
    logic             mg1;
    logic             mg0;
    logic [7:0]       cmd;
    logic [2:0]       idx;
    logic [5:0][15:0] slot;
    logic [7:0]       pprot;
    logic [7:0]       eprot;
    logic             margin;
    logic [7:0]       rdata;
  } fecp_regs_t;

endpackage : fecp_pkg

// file: fecp_core.sv
/*
  Command and protection logic of a program flash and data EEPROM
  controller. Holds status, command, parameter slots and protection
  registers behind a plain register port, and models command effects.
  Assumes a synchronous single-clock environment, an array interface
  outside that reports blank check and read error results, and a
  configuration byte presented in the first cycle after reset.
*/
// The implementer's own choices: the strobed register port and the address map.
`include "fecp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module fecp_core #(
  parameter int EXEC_CYCLES = 4
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        special_mode,
  input  wire logic [7:0]  config_byte,
  input  wire logic        blank_fail,
  input  wire logic        read_err,
  input  wire logic        read_uncorr,
  input  wire logic [2:0]  pflash_op,
  input  wire logic [63:0] once_phrase,
  output logic      [2:0]  once_index,
  output logic             concurrency_ok,
  output logic             margin_active,
  output logic             busy
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Scenario code from the protection register: open, high, low bits.
  function automatic logic [2:0] scen(input logic [7:0] p);
    scen = {p[`FECP_PP_OPEN], p[`FECP_PP_HDIS], p[`FECP_PP_LDIS]};
  endfunction : scen

  // Allowed transitions between scenarios in normal mode.
  function automatic logic scen_ok(input logic [2:0] f,
                                   input logic [2:0] t);
    case (f)
      3'h0:    scen_ok = (t <= 3'h3);
      3'h1:    scen_ok = (t == 3'h1) || (t == 3'h3);
      3'h2:    scen_ok = (t == 3'h2) || (t == 3'h3);
      3'h3:    scen_ok = (t == 3'h3);
      3'h4:    scen_ok = (t == 3'h3) || (t == 3'h4);
      3'h5:    scen_ok = (t >= 3'h2) && (t <= 3'h5);
      3'h6:    scen_ok = (t == 3'h1) || (t == 3'h3) ||
                         (t == 3'h4) || (t == 3'h6);
      default: scen_ok = 1'b1;
    endcase
  endfunction : scen_ok

  // EEPROM operation class of a command code.
  function automatic fecp_pkg::fecp_op_t ee_op(input logic [7:0] c,
                                               input logic m);
    case (c)
      `FECP_CMD_ERALL, `FECP_CMD_ERBLK,
      `FECP_CMD_UNSEC: ee_op = fecp_pkg::FECP_OP_MASS;
      `FECP_CMD_PGMEE: ee_op = fecp_pkg::FECP_OP_PROG;
      `FECP_CMD_ERSEC: ee_op = fecp_pkg::FECP_OP_SERA;
      `FECP_CMD_EVEE:  ee_op = m ? fecp_pkg::FECP_OP_MREAD
                                 : fecp_pkg::FECP_OP_READ;
      default:         ee_op = fecp_pkg::FECP_OP_NONE;
    endcase
  endfunction : ee_op

  // ----------------------------------------------------------------
  // State and decode
  // ----------------------------------------------------------------
  fecp_pkg::fecp_regs_t r_q;   // Registered state.
  fecp_pkg::fecp_regs_t r_d;   // Next state.
  logic                 wr_ok; // Writes allowed now.
  logic [17:0]          gaddr; // Section start address.
  logic [18:0]          gend;  // Section end (exclusive).
  logic                 ev_bad;
  logic [7:0]           ep_new;
  fecp_pkg::fecp_op_t   eop;

  // Writes land when idle or during init, never while a command executes.
  assign wr_ok = (r_q.st != fecp_pkg::FECP_EXEC);

  // Section verify address from slots 0 and 1, range inside block.
  assign gaddr = {r_q.slot[0][1:0], r_q.slot[1]};
  assign gend  = {1'b0, gaddr} + {r_q.slot[2], 3'h0};
  assign ev_bad = (r_q.idx != `FECP_IDX_LAST2) ||
                  (r_q.slot[0][1:0] != `FECP_PF_BANK) ||
                  (gaddr[2:0] != 3'h0) ||
                  (gend > ({1'b0, `FECP_HIGH_TOP} + 19'h1));

  // Concurrency: program flash read alongside EEPROM margin read,
  // program or sector erase; or mass erase alongside mass erase.
  assign eop = (r_q.st == fecp_pkg::FECP_EXEC)
             ? ee_op(r_q.cmd, r_q.margin) : fecp_pkg::FECP_OP_NONE;
  always_comb begin
    concurrency_ok = 1'b1;
    if ((pflash_op != fecp_pkg::FECP_OP_NONE) &&
        (eop != fecp_pkg::FECP_OP_NONE)) begin
      concurrency_ok =
        ((pflash_op == fecp_pkg::FECP_OP_READ) &&
         ((eop == fecp_pkg::FECP_OP_MREAD) ||
          (eop == fecp_pkg::FECP_OP_PROG) ||
          (eop == fecp_pkg::FECP_OP_SERA))) ||
        ((pflash_op == fecp_pkg::FECP_OP_MASS) &&
         (eop == fecp_pkg::FECP_OP_MASS));
    end
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------

  // All register writes, launch, command execution and reads.
  always_comb begin
    r_d       = r_q;
    r_d.rdata = 8'h00;
    ep_new    = reg_wdata;
    // Init loads the protection byte once, on its first cycle, so that
    // a software write made later in init is not overwritten.
    if (r_q.st == fecp_pkg::FECP_INIT) begin
      if (r_q.cnt == 4'h0) begin
        r_d.eprot = config_byte;
      end
      r_d.cnt = r_q.cnt + 4'h1;
      if (r_q.cnt == `FECP_INIT_CYC) begin
        r_d.st  = fecp_pkg::FECP_IDLE;
        r_d.ccf = 1'b1;
      end
    end
    case (r_q.st)
      fecp_pkg::FECP_EXEC: begin
        r_d.cnt = r_q.cnt + 4'h1;
        if (r_q.cnt == EXEC_CYCLES[3:0]) begin
          r_d.st  = fecp_pkg::FECP_IDLE;
          r_d.ccf = 1'b1;
          r_d.cnt = 4'h0;
          case (r_q.cmd)
            `FECP_CMD_EVSEC, `FECP_CMD_EVEE: begin
              // Dirty section sets both; read faults split.
              r_d.mg1 = blank_fail | read_err;
              r_d.mg0 = blank_fail | read_uncorr;
            end
            `FECP_CMD_UNSEC: begin
              // Erase then verify everything is blank.
              r_d.mg1 = blank_fail;
              r_d.mg0 = blank_fail;
            end
            `FECP_CMD_RDONCE: begin
              // Four result words into slots 2 to 5.
              for (int i = 0; i < 4; i++) begin
                r_d.slot[i + 2] = once_phrase[i * 16 +: 16];
              end
            end
            `FECP_CMD_UMARG, `FECP_CMD_FMARG: begin
              // Non-zero level makes later reads margin reads.
              r_d.margin = (r_q.slot[1] != 16'h0000);
            end
            default: begin
              r_d.mg1 = 1'b0;
            end
          endcase
        end
      end
      default: begin
        // Idle or init: accept software writes.
        if (reg_wr && wr_ok) begin
          case (reg_addr)
            `FECP_OFF_STAT: begin
              // Write one clears errors; clearing CCF launches.
              if (reg_wdata[`FECP_ST_ACC]) r_d.acc = 1'b0;
              if (reg_wdata[`FECP_ST_PV])  r_d.pv  = 1'b0;
              // Launch needs the completion flag up, so a status write
              // made during init clears errors but never launches.
              if (reg_wdata[`FECP_ST_CCF] && r_q.ccf &&
                  !r_q.acc && !r_q.pv) begin
                r_d.mg1 = 1'b0;
                r_d.mg0 = 1'b0;
                r_d.cnt = 4'h0;
                r_d.st  = fecp_pkg::FECP_EXEC;
                r_d.ccf = 1'b0;
                case (r_q.cmd)
                  `FECP_CMD_EVSEC: begin
                    if (ev_bad) begin
                      r_d.acc = 1'b1;
                      r_d.st  = fecp_pkg::FECP_IDLE;
                      r_d.ccf = 1'b1;
                    end
                  end
                  `FECP_CMD_RDONCE: begin
                    if (r_q.slot[1] > `FECP_ONCE_MAX) begin
                      r_d.acc = 1'b1;
                      r_d.st  = fecp_pkg::FECP_IDLE;
                      r_d.ccf = 1'b1;
                    end
                  end
                  `FECP_CMD_ERALL, `FECP_CMD_UNSEC: begin
                    if (r_q.cmd == `FECP_CMD_ERALL &&
                        !(r_q.pprot[`FECP_PP_LDIS] &&
                          r_q.pprot[`FECP_PP_HDIS] &&
                          r_q.pprot[`FECP_PP_OPEN] &&
                          r_q.eprot[`FECP_EP_OPEN])) begin
                      r_d.pv  = 1'b1;
                      r_d.st  = fecp_pkg::FECP_IDLE;
                      r_d.ccf = 1'b1;
                    end
                  end
                  `FECP_CMD_ERBLK: begin
                    // EEPROM block (any bank but 3) needs the open bit.
                    if (r_q.slot[0][1:0] != `FECP_PF_BANK &&
                        !r_q.eprot[`FECP_EP_OPEN]) begin
                      r_d.pv  = 1'b1;
                      r_d.st  = fecp_pkg::FECP_IDLE;
                      r_d.ccf = 1'b1;
                    end
                  end
                  `FECP_CMD_FMARG: begin
                    if (!special_mode) begin
                      r_d.acc = 1'b1;
                      r_d.st  = fecp_pkg::FECP_IDLE;
                      r_d.ccf = 1'b1;
                    end
                  end
                  `FECP_CMD_UMARG, `FECP_CMD_EVEE,
                  `FECP_CMD_PGMEE, `FECP_CMD_ERSEC: begin
                    r_d.st = fecp_pkg::FECP_EXEC;
                  end
                  default: begin
                    // Unknown command code is an access error.
                    r_d.acc = 1'b1;
                    r_d.st  = fecp_pkg::FECP_IDLE;
                    r_d.ccf = 1'b1;
                  end
                endcase
              end
            end
            `FECP_OFF_CMD:    r_d.cmd = reg_wdata;
            `FECP_OFF_IDX:    r_d.idx = reg_wdata[2:0];
            `FECP_OFF_SLOTHI: begin
              if (r_q.idx <= `FECP_IDX_MAX)
                r_d.slot[r_q.idx][15:8] = reg_wdata;
            end
            `FECP_OFF_SLOTLO: begin
              if (r_q.idx <= `FECP_IDX_MAX)
                r_d.slot[r_q.idx][7:0] = reg_wdata;
            end
            `FECP_OFF_PPROT: begin
              // Normal mode: only listed scenario moves apply.
              if (special_mode ||
                  scen_ok(scen(r_q.pprot), scen(reg_wdata)))
                r_d.pprot = reg_wdata;
            end
            `FECP_OFF_EPROT: begin
              // Open may only drop; size only grows while closed.
              if (special_mode) begin
                r_d.eprot = ep_new;
              end else if (!(ep_new[`FECP_EP_OPEN] &&
                             !r_q.eprot[`FECP_EP_OPEN]) &&
                           (r_q.eprot[`FECP_EP_OPEN] ||
                            ep_new[6:0] > r_q.eprot[6:0])) begin
                r_d.eprot = ep_new;
              end
            end
            default: begin
              r_d.cmd = r_q.cmd;
            end
          endcase
        end
      end
    endcase
    // Read data stands in the following cycle.
    if (reg_rd) begin
      case (reg_addr)
        `FECP_OFF_STAT: r_d.rdata = {r_q.ccf, 1'b0, r_q.acc, r_q.pv,
                                     2'b00, r_q.mg1, r_q.mg0};
        `FECP_OFF_CMD:    r_d.rdata = r_q.cmd;
        `FECP_OFF_IDX:    r_d.rdata = {5'h00, r_q.idx};
        `FECP_OFF_SLOTHI: r_d.rdata = (r_q.idx <= `FECP_IDX_MAX)
                                      ? r_q.slot[r_q.idx][15:8] : 8'h00;
        `FECP_OFF_SLOTLO: r_d.rdata = (r_q.idx <= `FECP_IDX_MAX)
                                      ? r_q.slot[r_q.idx][7:0] : 8'h00;
        `FECP_OFF_PPROT:  r_d.rdata = r_q.pprot;
        `FECP_OFF_EPROT:  r_d.rdata = r_q.eprot;
        `FECP_OFF_MODE:   r_d.rdata = {7'h00, r_q.margin};
        default:          r_d.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // Asynchronous reset to constants; EEPROM protection reloads in init.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r_q       <= '0;
      r_q.st    <= fecp_pkg::FECP_INIT;
      r_q.pprot <= `FECP_PP_RST;
      r_q.eprot <= `FECP_EP_RST;
    end else begin
      r_q <= r_d;
    end
  end

  // Outputs other than concurrency_ok come straight from the state register.
  assign reg_rdata     = r_q.rdata;
  assign once_index    = r_q.slot[1][2:0];
  assign margin_active = r_q.margin;
  assign busy          = !r_q.ccf;

endmodule : fecp_core

`default_nettype wire

// file: fecp_core_properties.sv
/*
  Port-level properties of fecp_core, bound into every instance.
  Assumes the bench holds both register strobes low during reset.
*/
`include "fecp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module fecp_core_properties (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic [3:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [2:0] pflash_op,
  input wire logic [2:0] once_index,
  input wire logic       concurrency_ok,
  input wire logic       margin_active,
  input wire logic       busy
);
  // ----------------------------------------------------------------
  // One clock domain, so clocking and reset are given once.
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Read data stands only in the cycle after a read strobe.
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
  // The completion bit read back is the inverse of busy.
  property p_stat_rd;
    $past(reg_rd) && $past(reg_addr) == `FECP_OFF_STAT
      |-> reg_rdata[`FECP_ST_CCF] == !$past(busy);
  endproperty
  a_stat_rd: assert property (p_stat_rd) else $error("flag mismatch");
  // The margin register mirrors the margin output in bit 0.
  property p_mode_rd;
    $past(reg_rd) && $past(reg_addr) == `FECP_OFF_MODE
      |-> reg_rdata == {7'h00, $past(margin_active)};
  endproperty
  a_mode_rd: assert property (p_mode_rd) else $error("margin readback");
  // Initialisation takes exactly four cycles after release.
  property p_init;
    $rose(rstn) |-> busy [*4] ##1 !busy;
  endproperty
  a_init: assert property (p_init) else $error("init length wrong");
  // A command never runs longer than its execution window.
  property p_busy_len;
    $rose(busy) |-> ##[1:5] !busy;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy too long");
  // The margin level only changes as a command completes.
  property p_margin_chg;
    $changed(margin_active) |-> $past(busy);
  endproperty
  a_margin_chg: assert property (p_margin_chg) else $error("margin moved");
  // The low bits of slot 1, seen as once_index, cannot move while a command runs.
  property p_idx_hold;
    busy && $past(busy) |-> $stable(once_index);
  endproperty
  a_idx_hold: assert property (p_idx_hold) else $error("slot changed");
  // Command code last written while idle; busy writes are dropped.
  logic [7:0] cmd_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmd_q <= 8'h00;
    end else if (reg_wr && !busy && reg_addr == `FECP_OFF_CMD) begin
      cmd_q <= reg_wdata;
    end
  end
  // A running EEPROM operation shuts out flash margin read, program
  // and sector erase.
  property p_cc;
    busy && pflash_op inside {3'h2, 3'h3, 3'h4} &&
      cmd_q inside {`FECP_CMD_ERALL, `FECP_CMD_ERBLK, `FECP_CMD_UNSEC,
                    `FECP_CMD_EVEE, `FECP_CMD_PGMEE, `FECP_CMD_ERSEC}
      |-> !concurrency_ok;
  endproperty
  a_cc: assert property (p_cc) else $error("overlap allowed");

  c_launch: cover property ($rose(busy));
  c_margin: cover property ($rose(margin_active));
  c_cc: cover property (busy && concurrency_ok);
endmodule : fecp_core_properties

bind fecp_core fecp_core_properties chk_u (
  .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .pflash_op(pflash_op), .once_index(once_index),
  .concurrency_ok(concurrency_ok), .margin_active(margin_active),
  .busy(busy)
);
`default_nettype wire

// file: fecp_array_model.sv
/*
  Array-side model: read results, flash activity and read-once data.
  Assumes the bench chooses faults per command and flash activity per cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module fecp_array_model (
  input  wire logic [2:0]  once_index,
  input  wire logic [2:0]  fault,
  input  wire logic [2:0]  op_sel,
  output logic             blank_fail,
  output logic             read_err,
  output logic             read_uncorr,
  output logic      [2:0]  pflash_op,
  output logic      [63:0] once_phrase
);
  // An uncorrectable error is also an error, so both lines rise.
  always_comb begin
    blank_fail  = fault[0];
    read_err    = fault[1] | fault[2];
    read_uncorr = fault[2];
    pflash_op   = op_sel;
    for (int i = 0; i < 4; i++) begin
      once_phrase[16*i +: 16] = 16'hA000 | {9'h000, once_index, 4'(i)};
    end
  end
endmodule : fecp_array_model
`default_nettype wire

// file: tb.sv
/*
  Self-checking bench for fecp_core against an array-side model.
  Assumes fecp_cfg.svh on the include path.
*/
`include "fecp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00, config_byte = 8'h80, reg_rdata;
  logic        special_mode = 1'b0, blank_fail, read_err, read_uncorr;
  logic [2:0]  fault = 3'h0, op_sel = 3'h0, once_index, pflash_op;
  logic        concurrency_ok, margin_active, busy;
  logic [63:0] once_phrase;
  logic [7:0]  st, d, h, o, v;
  int          n_mismatch = 0, compares = 0, f, t, i, j;
  localparam logic [7:0] ALLOW [8] = '{8'h0F, 8'h0A, 8'h0C, 8'h08,
                                      8'h18, 8'h3C, 8'h5A, 8'hFF};
  localparam logic [15:0] BS0 [4] = '{16'h0303, 16'h0303, 16'h0302, 16'h0303};
  localparam logic [15:0] BS1 [4] = '{16'h0000, 16'h0001, 16'h0000, 16'hFFF8};
  localparam logic [7:0] CMDS [6] = '{8'h08, 8'h09, 8'h0B, 8'h10, 8'h11, 8'h12};
  localparam int NS [6] = '{0, 0, 0, 2, 2, 1};
  localparam int CCS [6] = '{5, 5, 0, 7, 1, 1};

  always #5 clk = ~clk;

  fecp_core #(.EXEC_CYCLES(4)) dut_u (.clk(clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .special_mode(special_mode),
    .config_byte(config_byte), .blank_fail(blank_fail),
    .read_err(read_err), .read_uncorr(read_uncorr), .pflash_op(pflash_op),
    .once_phrase(once_phrase), .once_index(once_index),
    .concurrency_ok(concurrency_ok), .margin_active(margin_active),
    .busy(busy));
  fecp_array_model arr_u (.once_index(once_index), .fault(fault),
    .op_sel(op_sel), .blank_fail(blank_fail), .read_err(read_err),
    .read_uncorr(read_uncorr), .pflash_op(pflash_op),
    .once_phrase(once_phrase));

  // ----------------------------------------------------------------
  // Reporting and register port tasks.
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [15:0] a, input logic [15:0] e);
    compares++;
    if (a !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e);
    end
  endtask : chk
  task automatic chk_st(input logic [7:0] e);
    chk({8'h00, st & 8'hB3}, {8'h00, e});
  endtask : chk_st
  // The write strobe stays up so back-to-back writes never toggle it.
  task automatic wr(input logic [3:0] a, input logic [7:0] x);
    reg_addr <= a;
    reg_wdata <= x;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] x);
    reg_addr <= a;
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    x = reg_rdata;
  endtask : rd
  // Loads slots, launches, pokes a write mid-run, waits and reads status.
  task automatic go(input logic [7:0] c, input logic [15:0] s0, s1, s2,
                    input int n, input int cc);
    logic [15:0] s [3];
    int k;
    s = '{s0, s1, s2};
    wr(`FECP_OFF_STAT, 8'h30);
    wr(`FECP_OFF_CMD, c);
    for (k = 0; k <= n; k++) begin
      wr(`FECP_OFF_IDX, 8'(k));
      wr(`FECP_OFF_SLOTHI, s[k][15:8]);
      wr(`FECP_OFF_SLOTLO, s[k][7:0]);
    end
    wr(`FECP_OFF_STAT, 8'h80);
    for (k = 0; k < 20 && (k < 2 || busy); k++) begin
      reg_addr <= `FECP_OFF_EPROT;
      reg_wdata <= 8'h00;
      reg_wr <= (k == 2);
      op_sel <= 3'($urandom_range(5, 1));
      @(posedge clk);
      #1;
      if (cc != 0 && busy === 1'b1)
        chk({15'h0, concurrency_ok}, {15'h0, op_sel == 3'(cc)});
    end
    if (k == 20) begin
      n_mismatch++;
      stop_test();
    end
    rd(`FECP_OFF_STAT, st);
  endtask : go

  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(98));
    config_byte <= {1'b1, 7'($urandom)};
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    wr(`FECP_OFF_CMD, 8'h5A);
    reg_wr <= 1'b0;
    repeat (2) @(posedge clk);
    rd(`FECP_OFF_STAT, st);
    chk_st(8'h80);
    rd(`FECP_OFF_CMD, d);
    chk({8'h0, d}, 16'h005A);
    rd(`FECP_OFF_EPROT, d);
    chk({8'h0, d}, {8'h0, config_byte});
    $display("test 1 finished");
    // Every scenario pair: set in special mode, then request in normal.
    for (f = 0; f < 8; f++) begin
      for (t = 0; t < 8; t++) begin
        special_mode <= 1'b1;
        wr(`FECP_OFF_PPROT, {f[2], 1'b0, f[1], 2'b00, f[0], 2'b00});
        special_mode <= 1'b0;
        wr(`FECP_OFF_PPROT, {t[2], 1'b0, t[1], 2'b00, t[0], 2'b00});
        rd(`FECP_OFF_PPROT, d);
        v = ALLOW[f][t] ? 8'(t) : 8'(f);
        chk({8'h0, d & 8'hA4}, {8'h0, v[2], 1'b0, v[1], 2'b00, v[0], 2'b00});
      end
    end
    $display("test 2 finished");
    repeat (8) begin
      o = 8'($urandom_range(127));
      v = 8'($urandom);
      special_mode <= 1'b1;
      wr(`FECP_OFF_EPROT, o);
      special_mode <= 1'b0;
      wr(`FECP_OFF_EPROT, v);
      rd(`FECP_OFF_EPROT, d);
      chk({8'h0, d}, {8'h0, (!v[7] && v[6:0] > o[6:0]) ? v : o});
    end
    special_mode <= 1'b1;
    wr(`FECP_OFF_EPROT, 8'h80);
    rd(`FECP_OFF_EPROT, d);
    chk({8'h0, d}, 16'h0080);
    $display("test 3 finished");
    go(8'h0D, 16'h0D00, 16'h0001, 16'h0, 1, 0);
    chk_st(8'h80);
    chk({15'h0, margin_active}, 16'h0001);
    rd(`FECP_OFF_EPROT, d);
    chk({8'h0, d}, 16'h0080);
    go(8'h0D, 16'h0D00, 16'h0000, 16'h0, 1, 0);
    chk({15'h0, margin_active}, 16'h0000);
    special_mode <= 1'b0;
    go(8'h0E, 16'h0E00, 16'h0002, 16'h0, 1, 0);
    chk_st(8'hA0);
    special_mode <= 1'b1;
    go(8'h0E, 16'h0E00, 16'h0002, 16'h0, 1, 0);
    chk({15'h0, margin_active}, 16'h0001);
    rd(`FECP_OFF_MODE, d);
    chk({8'h0, d}, 16'h0001);
    go(8'h10, 16'h1000, 16'h0400, 16'h0002, 2, 1);
    chk_st(8'h80);
    go(8'h0D, 16'h0D00, 16'h0000, 16'h0, 1, 0);
    $display("test 4 finished");
    for (f = 0; f < 8; f++) begin
      fault <= 3'(f);
      go(8'h03, 16'h0303, 16'h0000, 16'h0004, 2, 0);
      chk_st({6'h20, f[0] | f[1] | f[2], f[0] | f[2]});
    end
    fault <= 3'h0;
    for (i = 0; i < 4; i++) begin
      go(8'h03, BS0[i], BS1[i], 16'h0002, (i == 0) ? 1 : 2, 0);
      chk_st(8'hA0);
    end
    $display("test 5 finished");
    for (i = 0; i <= 8; i++) begin
      go(8'h04, 16'h0400, 16'(i), 16'h0, 1, 0);
      chk_st((i < 8) ? 8'h80 : 8'hA0);
      chk({13'h0, once_index}, 16'(i & 7));
      for (j = 2; j < 6 && i < 8; j++) begin
        wr(`FECP_OFF_IDX, 8'(j));
        rd(`FECP_OFF_SLOTHI, h);
        rd(`FECP_OFF_SLOTLO, d);
        chk({h, d}, 16'hA000 + 16'(i * 16 + j - 2));
      end
    end
    $display("test 6 finished");
    for (i = 0; i < 6; i++) begin
      go(CMDS[i], {CMDS[i], 8'h00}, 16'h0400, 16'h0002, NS[i], CCS[i]);
      chk_st(8'h80);
    end
    wr(`FECP_OFF_EPROT, 8'h05);
    for (i = 0; i < 2; i++) begin
      go(CMDS[i], {CMDS[i], 8'h00}, 16'h0, 16'h0, 0, 0);
      chk_st(8'h90);
    end
    go(8'h7F, 16'h7F00, 16'h0, 16'h0, 0, 0);
    chk_st(8'hA0);
    $display("test 7 finished");
    stop_test();
  end
endmodule : tb
`default_nettype wire
